// ---- bench/mes_mode_entry_sequencer_tb.sv ----
// Self-checking testbench for the mode entry sequencer
`timescale 1ns/10ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin errorCnt++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end
module mes_mode_entry_sequencer_tb;
  import mes_pkg::*;
  logic mclk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rdat;
  logic oscStableIn = 1'b0, pllLockedIn = 1'b0, wakeupIn = 1'b0;
  logic safeFailIn = 1'b0, resetFailIn = 1'b0, waitEntry = 1'b0;
  logic hreadyout, hresp, irq, oscEnable, pllEnable, flashEnable, mainRegEnable;
  logic [31:0] hrdata;
  logic [3:0] currentMode;
  int errorCnt = 0, comparisons = 0;

  mes_mode_entry_sequencer dut_u (
    .mclk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .oscStableIn, .pllLockedIn, .wakeupIn, .safeFailIn, .resetFailIn, .waitEntry,
    .oscEnable, .pllEnable, .flashEnable, .mainRegEnable, .currentMode, .irq
  );

  always #50 mclk = ~mclk;

  // =============================================================
  // Bus and wait helpers
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, errorCnt);
    if (errorCnt == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic bound(input int n);
    if (n >= 200) begin
      errorCnt++;
      report_and_stop();
    end
  endtask : bound

  // Values seen right after the edge are the ones sampled at it
  task automatic rdy;
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 200);
    bound(n);
  endtask : rdy

  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    rdat = hrdata;
  endtask : xfer

  task automatic chk_rd(input logic [31:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK("read data", e, rdat)
  endtask : chk_rd

  task automatic req(input mes_mode_t m, input logic [15:0] k);
    xfer(1'b1, MES_ADDR_MCTL, {m, 12'h000, MES_KEY});
    xfer(1'b1, MES_ADDR_MCTL, {m, 12'h000, k});
  endtask : req

  // Software side of a low-power request: read status until the change is over
  task automatic poll_idle;
    int n;
    n = 0;
    do begin
      xfer(1'b0, MES_ADDR_GS, 32'h0);
      n++;
    end while (rdat[MES_GS_MTRANS] !== 1'b0 && n < 200);
    bound(n);
  endtask : poll_idle

  task automatic wm(input mes_mode_t m);
    int n;
    n = 0;
    while (currentMode !== m && n < 200) begin
      @(posedge mclk);
      n++;
    end
    bound(n);
    `CHK("currentMode", m, currentMode)
  endtask : wm

  // =============================================================
  // Scenarios
  task automatic t_reset;
    `CHK("currentMode", MES_M_DEFAULT_RUN, currentMode)
    `CHK("hresp", 1'b0, hresp)
    `CHK("irq", 1'b0, irq)
    chk_rd(MES_ADDR_ME, 32'h0000001d);
    chk_rd(MES_ADDR_GS, {MES_M_DEFAULT_RUN, 1'b0, 1'b1, 26'h0});
    xfer(1'b1, 32'hc3fdc8fc, 32'hffffffff);
    chk_rd(32'hc3fdc8fc, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_mask;
    xfer(1'b1, MES_ADDR_ME, 32'hffffffff);
    chk_rd(MES_ADDR_ME, 32'h000025ff);
    xfer(1'b1, MES_ADDR_ME, 32'h0);
    chk_rd(MES_ADDR_ME, 32'h0000001d);
    $display("test mask done");
  endtask : t_mask

  task automatic t_illegal;
    req(4'h5, MES_KEY_INV);
    chk_rd(MES_ADDR_IRQ_STAT, 32'h2);
    `CHK("currentMode", MES_M_DEFAULT_RUN, currentMode)
    `CHK("irq", 1'b0, irq)
    xfer(1'b1, MES_ADDR_IRQ_EN, 32'h3);
    @(posedge mclk);
    `CHK("irq", 1'b1, irq)
    xfer(1'b1, MES_ADDR_IRQ_CLR, 32'h2);
    @(posedge mclk);
    `CHK("irq", 1'b0, irq)
    chk_rd(MES_ADDR_IRQ_STAT, 32'h0);
    $display("test illegal done");
  endtask : t_illegal

  // Target config enables oscillator and flash only, so PLL lock must not matter
  task automatic t_run;
    xfer(1'b1, MES_ADDR_ME, 32'h000025e2);
    xfer(1'b1, MES_ADDR_CFG0 + 32'h14, 32'h5);
    req(4'h5, MES_KEY_INV);
    repeat (20) @(posedge mclk);
    chk_rd(MES_ADDR_GS, {MES_M_DEFAULT_RUN, 1'b1, 1'b0, 26'h0});
    `CHK("oscEnable", 1'b1, oscEnable)
    `CHK("pllEnable", 1'b0, pllEnable)
    `CHK("flashEnable", 1'b1, flashEnable)
    `CHK("mainRegEnable", 1'b0, mainRegEnable)
    oscStableIn <= 1'b1;
    wm(4'h5);
    chk_rd(MES_ADDR_GS, {4'h5, 1'b0, 1'b0, 26'h0});
    chk_rd(MES_ADDR_IRQ_STAT, 32'h1);
    `CHK("irq", 1'b1, irq)
    xfer(1'b1, MES_ADDR_CFG0 + 32'h14, 32'hf);
    repeat (5) @(posedge mclk);
    `CHK("pllEnable", 1'b0, pllEnable)
    $display("test run done");
  endtask : t_run

  task automatic t_key;
    req(MES_M_DEFAULT_RUN, MES_KEY);
    xfer(1'b1, MES_ADDR_MCTL, {MES_M_DEFAULT_RUN, 12'h000, MES_KEY});
    xfer(1'b1, MES_ADDR_MCTL, {4'h6, 12'h000, MES_KEY_INV});
    repeat (10) @(posedge mclk);
    chk_rd(MES_ADDR_GS, {4'h5, 1'b0, 1'b0, 26'h0});
    $display("test key done");
  endtask : t_key

  task automatic t_hw;
    xfer(1'b1, MES_ADDR_IRQ_CLR, 32'h3);
    pllLockedIn <= 1'b1;
    waitEntry <= 1'b1;
    @(posedge mclk);
    waitEntry <= 1'b0;
    wm(MES_M_HALT);
    chk_rd(MES_ADDR_IRQ_STAT, 32'h1);
    xfer(1'b1, MES_ADDR_IRQ_CLR, 32'h3);
    wakeupIn <= 1'b1;
    wm(4'h5);
    wakeupIn <= 1'b0;
    xfer(1'b1, MES_ADDR_IRQ_CLR, 32'h3);
    // Software low-power entry: polled, and no done flag
    req(MES_M_STOP, MES_KEY_INV);
    poll_idle();
    `CHK("currentMode", MES_M_STOP, currentMode)
    chk_rd(MES_ADDR_IRQ_STAT, 32'h0);
    wakeupIn <= 1'b1;
    wm(4'h5);
    wakeupIn <= 1'b0;
    xfer(1'b1, MES_ADDR_IRQ_CLR, 32'h3);
    safeFailIn <= 1'b1;
    wm(MES_M_SAFE);
    chk_rd(MES_ADDR_IRQ_STAT, 32'h0);
    resetFailIn <= 1'b1;
    wm(MES_M_RESET);
    chk_rd(MES_ADDR_GS, {MES_M_RESET, 1'b0, 1'b1, 26'h0});
    $display("test hardware done");
  endtask : t_hw

  // =============================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_mask();
    t_illegal();
    t_run();
    t_key();
    t_hw();
    report_and_stop();
  end
endmodule : mes_mode_entry_sequencer_tb

// ---- core/mes_cfg_mem.sv ----
// Per-mode configuration store, one write port and two registered read ports
`timescale 1ns/10ps
module mes_cfg_mem #(
  parameter int AW = 4,
  parameter int W = 4,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic [AW-1:0] raddrA,
  output logic [W-1:0] rdataA,
  input wire logic [AW-1:0] raddrB,
  output logic [W-1:0] rdataB
);
  localparam int DEPTH = 1 << AW;
  logic [W-1:0] mem [DEPTH];

  initial begin
    if (AW < 1 || W < 1) $error("mes_cfg_mem: AW and W must be positive");
  end

  // =============================================================
  // Entries reset to a known configuration so every mode is usable
  for (genvar e = 0; e < DEPTH; e++) begin : gEntry
    always_ff @(posedge mclk) begin
      if (rst) begin
        mem[e] <= RST_VAL;
      end else if (we && waddr == AW'(e)) begin
        mem[e] <= wdata;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rdataA <= '0;
      rdataB <= RST_VAL;
    end else begin
      rdataA <= mem[raddrA];
      rdataB <= mem[raddrB];
    end
  end
endmodule : mes_cfg_mem

// ---- core/mes_mode_entry_sequencer.sv ----
// Mode entry sequencer: mode mask, keyed transitions, config apply, status and interrupts
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module mes_mode_entry_sequencer (
  input wire logic mclk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic oscStableIn,
  input wire logic pllLockedIn,
  input wire logic wakeupIn,
  input wire logic safeFailIn,
  input wire logic resetFailIn,
  input wire logic waitEntry,
  output logic oscEnable,
  output logic pllEnable,
  output logic flashEnable,
  output logic mainRegEnable,
  output logic [3:0] currentMode,
  output logic irq
);
  import mes_pkg::*;

  function automatic logic isRun(input mes_mode_t m);
    return (m >= MES_M_DEFAULT_RUN) && (m <= MES_M_APP_RUN_THREE);
  endfunction : isRun

  function automatic logic isLowPower(input mes_mode_t m);
    return (m == MES_M_HALT) || (m == MES_M_STOP) || (m == MES_M_STANDBY);
  endfunction : isLowPower

  // =============================================================
  // Pin inputs
  logic [MES_SYNC_W-1:0] pinSync;
  logic safePrev_reg, resetPrev_reg;
  logic safeRise, resetRise;

  mes_sync #(.W(MES_SYNC_W)) uSync (
    .mclk(mclk),
    .rst(rst),
    .din({resetFailIn, safeFailIn, wakeupIn, pllLockedIn, oscStableIn}),
    .dout(pinSync)
  );

  always_ff @(posedge mclk) begin
    if (rst) begin
      safePrev_reg <= 1'b0;
      resetPrev_reg <= 1'b0;
    end else begin
      safePrev_reg <= pinSync[MES_PIN_SAFE];
      resetPrev_reg <= pinSync[MES_PIN_RESET];
    end
  end
  assign safeRise = pinSync[MES_PIN_SAFE] & ~safePrev_reg;
  assign resetRise = pinSync[MES_PIN_RESET] & ~resetPrev_reg;

  // =============================================================
  // AHB-Lite slave: writes with no wait state, reads with two
  logic dphWrite_reg, dphRead_reg;
  logic [31:0] dphAddr_reg;
  logic [1:0] rdStep_reg;
  logic [31:0] hrdata_reg;
  logic accept, wrEn, mctlWr;

  assign accept = hsel & hready & htrans[MES_HTRANS_ACT];
  assign hreadyout = (rdStep_reg == MES_RD_IDLE) || (rdStep_reg == MES_RD_LAST);
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;
  assign wrEn = dphWrite_reg;
  assign mctlWr = wrEn && (dphAddr_reg == MES_ADDR_MCTL);

  always_ff @(posedge mclk) begin
    if (rst) begin
      dphWrite_reg <= 1'b0;
      dphRead_reg <= 1'b0;
      dphAddr_reg <= '0;
    end else if (accept) begin
      dphWrite_reg <= hwrite;
      dphRead_reg <= ~hwrite;
      dphAddr_reg <= haddr;
    end else if (hready) begin
      dphWrite_reg <= 1'b0;
      dphRead_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rdStep_reg <= MES_RD_IDLE;
    end else if (accept && !hwrite) begin
      rdStep_reg <= MES_RD_FIRST;
    end else if (rdStep_reg == MES_RD_LAST) begin
      rdStep_reg <= MES_RD_IDLE;
    end else if (rdStep_reg != MES_RD_IDLE) begin
      rdStep_reg <= rdStep_reg + 2'h1;
    end
  end

  // =============================================================
  // Software registers
  logic [31:0] maskW_reg, maskRd;
  logic keyArmed_reg;
  mes_mode_t keyMode_reg, swMode;
  logic swReq;
  logic [MES_IRQ_W-1:0] irqStat_reg, irqEn_reg, irqSet, irqClr;

  assign maskRd = maskW_reg | MES_ME_FIXED;
  assign swMode = hwdata[MES_MCTL_MODE_LSB +: 4];
  // Second write must repeat the target and carry the inverted key
  assign swReq = mctlWr && keyArmed_reg && (hwdata[15:0] == MES_KEY_INV) && (swMode == keyMode_reg);

  always_ff @(posedge mclk) begin
    if (rst) begin
      maskW_reg <= MES_ME_RST;
    end else if (wrEn && dphAddr_reg == MES_ADDR_ME) begin
      maskW_reg <= hwdata & MES_ME_WRITABLE;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      keyArmed_reg <= 1'b0;
      keyMode_reg <= MES_M_DEFAULT_RUN;
    end else if (mctlWr) begin
      // Any control write other than a valid first write disarms the key
      keyArmed_reg <= !keyArmed_reg && (hwdata[15:0] == MES_KEY);
      keyMode_reg <= swMode;
    end
  end

  assign irqClr = (wrEn && dphAddr_reg == MES_ADDR_IRQ_CLR) ? hwdata[MES_IRQ_W-1:0] : '0;

  always_ff @(posedge mclk) begin
    if (rst) begin
      irqStat_reg <= '0;
    end else begin
      // Set wins over a clear in the same cycle
      irqStat_reg <= (irqStat_reg & ~irqClr) | irqSet;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      irqEn_reg <= '0;
    end else if (wrEn && dphAddr_reg == MES_ADDR_IRQ_EN) begin
      irqEn_reg <= hwdata[MES_IRQ_W-1:0];
    end
  end
  assign irq = |(irqStat_reg & irqEn_reg);

  // =============================================================
  // Configuration store
  logic cfgWe;
  logic [MES_CFG_W-1:0] busRdData, seqRdData;
  mes_mode_t target_reg;

  assign cfgWe = wrEn && (dphAddr_reg[31:MES_CFG_BLK_LSB] == MES_ADDR_CFG0[31:MES_CFG_BLK_LSB]);

  mes_cfg_mem #(.AW(MES_CFG_AW), .W(MES_CFG_W), .RST_VAL(MES_CFG_RST)) uCfg (
    .mclk(mclk),
    .rst(rst),
    .we(cfgWe),
    .waddr(dphAddr_reg[2 +: MES_CFG_AW]),
    .wdata(hwdata[MES_CFG_W-1:0]),
    .raddrA(dphAddr_reg[2 +: MES_CFG_AW]),
    .rdataA(busRdData),
    .raddrB(target_reg),
    .rdataB(seqRdData)
  );

  // =============================================================
  // Transition requests, highest priority first
  mes_state_e state_reg;
  mes_mode_t curMode_reg, resumeMode_reg, startMode;
  logic viaWait_reg, startReq, startWait, startSw, illReq, wakeReq;

  assign wakeReq = pinSync[MES_PIN_WAKE] && isLowPower(curMode_reg);

  always_comb begin
    startReq = 1'b0;
    startMode = curMode_reg;
    startWait = 1'b0;
    startSw = 1'b0;
    illReq = 1'b0;
    if (resetRise) begin
      startReq = 1'b1;
      startMode = MES_M_RESET;
    end else if (safeRise) begin
      startReq = 1'b1;
      startMode = MES_M_SAFE;
    end else if (state_reg == MES_ST_IDLE) begin
      if (wakeReq) begin
        startReq = 1'b1;
        startMode = resumeMode_reg;
      end else if (waitEntry && isRun(curMode_reg)) begin
        startReq = maskRd[MES_M_HALT];
        startMode = MES_M_HALT;
        startWait = 1'b1;
        illReq = !maskRd[MES_M_HALT];
      end else if (swReq) begin
        startReq = maskRd[swMode];
        startSw = maskRd[swMode];
        startMode = swMode;
        illReq = !maskRd[swMode];
      end
    end
  end

  // =============================================================
  // Sequencer
  logic [MES_CFG_W-1:0] activeCfg_reg;
  logic cfgReady, transDone, transInProg;

  // Stable and locked only count for sources the new mode switches on
  assign cfgReady = (!activeCfg_reg[MES_CFG_OSC] || pinSync[MES_PIN_OSC]) &&
                    (!activeCfg_reg[MES_CFG_PLL] || pinSync[MES_PIN_PLL]);
  assign transDone = (state_reg == MES_ST_WAIT) && cfgReady && !startReq;
  assign transInProg = (state_reg != MES_ST_IDLE);
  assign irqSet[MES_IRQ_DONE] = transDone && (isRun(target_reg) || viaWait_reg);
  assign irqSet[MES_IRQ_ILL] = illReq;

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg <= MES_ST_IDLE;
      target_reg <= MES_M_DEFAULT_RUN;
      viaWait_reg <= 1'b0;
    end else if (startReq) begin
      state_reg <= MES_ST_FETCH;
      target_reg <= startMode;
      viaWait_reg <= startWait;
    end else begin
      unique case (state_reg)
        MES_ST_IDLE: state_reg <= MES_ST_IDLE;
        MES_ST_FETCH: state_reg <= MES_ST_APPLY;
        MES_ST_APPLY: state_reg <= MES_ST_WAIT;
        MES_ST_WAIT: begin
          if (cfgReady) begin
            state_reg <= MES_ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      curMode_reg <= MES_M_DEFAULT_RUN;
      resumeMode_reg <= MES_M_DEFAULT_RUN;
    end else if (transDone) begin
      curMode_reg <= target_reg;
      // Wake-up returns to the mode that was running before low power
      if (isLowPower(target_reg) && !isLowPower(curMode_reg)) begin
        resumeMode_reg <= curMode_reg;
      end
    end
  end

  // Configuration is latched only on entry, so later edits wait for the next entry
  always_ff @(posedge mclk) begin
    if (rst) begin
      activeCfg_reg <= MES_CFG_RST;
    end else if (state_reg == MES_ST_APPLY) begin
      activeCfg_reg <= seqRdData;
    end
  end

  assign oscEnable = activeCfg_reg[MES_CFG_OSC];
  assign pllEnable = activeCfg_reg[MES_CFG_PLL];
  assign flashEnable = activeCfg_reg[MES_CFG_FLASH];
  assign mainRegEnable = activeCfg_reg[MES_CFG_MVREG];
  assign currentMode = curMode_reg;

  // =============================================================
  // Read data
  logic [31:0] gsRd, rdMux;
  always_comb begin
    gsRd = '0;
    gsRd[MES_GS_MODE_LSB +: 4] = curMode_reg;
    gsRd[MES_GS_MTRANS] = transInProg;
    gsRd[MES_GS_DC] = activeCfg_reg[MES_CFG_MVREG];
  end

  always_comb begin
    rdMux = '0;
    if (cfgWe || (dphAddr_reg[31:MES_CFG_BLK_LSB] == MES_ADDR_CFG0[31:MES_CFG_BLK_LSB])) begin
      rdMux[MES_CFG_W-1:0] = busRdData;
    end else if (dphAddr_reg == MES_ADDR_ME) begin
      rdMux = maskRd;
    end else if (dphAddr_reg == MES_ADDR_GS) begin
      rdMux = gsRd;
    end else if (dphAddr_reg == MES_ADDR_MCTL) begin
      rdMux[MES_MCTL_MODE_LSB +: 4] = keyMode_reg;
    end else if (dphAddr_reg == MES_ADDR_IRQ_STAT) begin
      rdMux[MES_IRQ_W-1:0] = irqStat_reg;
    end else if (dphAddr_reg == MES_ADDR_IRQ_EN) begin
      rdMux[MES_IRQ_W-1:0] = irqEn_reg;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      hrdata_reg <= '0;
    end else if (dphRead_reg && rdStep_reg == MES_RD_LOAD) begin
      hrdata_reg <= rdMux;
    end
  end

  // =============================================================
  // Checks
  sequence seqFetchApply;
    (state_reg == MES_ST_FETCH) ##1 (state_reg == MES_ST_APPLY);
  endsequence

  AST_MASK_CHECK: assert property (@(posedge mclk) disable iff (rst)
    (swReq && !maskRd[swMode] && !resetRise && !safeRise && !wakeReq && !waitEntry)
    |=> !(state_reg == MES_ST_FETCH))
    else $error("disabled mode was entered");
  AST_ILLEGAL_IRQ: assert property (@(posedge mclk) disable iff (rst)
    illReq |=> irqStat_reg[MES_IRQ_ILL] && (curMode_reg == $past(curMode_reg)))
    else $error("illegal mode request not flagged");
  AST_FIXED_EN: assert property (@(posedge mclk) disable iff (rst)
    (maskRd & MES_ME_FIXED) == MES_ME_FIXED)
    else $error("fixed mode enable bit reads zero");
  AST_RESERVED_ZERO: assert property (@(posedge mclk) disable iff (rst)
    (maskRd & ~(MES_ME_FIXED | MES_ME_WRITABLE)) == 32'h0)
    else $error("reserved mask bit set");
  AST_SW_START: assert property (@(posedge mclk) disable iff (rst)
    startSw |=> transInProg && (target_reg == $past(swMode)) ##1 transInProg)
    else $error("keyed request did not start a transition");
  AST_MTRANS_END: assert property (@(posedge mclk) disable iff (rst)
    transDone |=> !transInProg && (curMode_reg == $past(target_reg)))
    else $error("transition end not reported");
  AST_DONE_FLAG: assert property (@(posedge mclk) disable iff (rst)
    (transDone && isRun(target_reg)) |=> irqStat_reg[MES_IRQ_DONE])
    else $error("run transition did not set done flag");
  AST_LP_NOFLAG: assert property (@(posedge mclk) disable iff (rst)
    (transDone && isLowPower(target_reg) && !viaWait_reg && !irqStat_reg[MES_IRQ_DONE])
    |=> !irqStat_reg[MES_IRQ_DONE])
    else $error("low-power entry set done flag");
  AST_CFG_APPLY: assert property (@(posedge mclk) disable iff (rst)
    (seqFetchApply ##0 !startReq) |=> (activeCfg_reg == $past(seqRdData)))
    else $error("target configuration not applied");
  AST_WAIT_READY: assert property (@(posedge mclk) disable iff (rst)
    ((state_reg == MES_ST_WAIT) && activeCfg_reg[MES_CFG_PLL] && !pinSync[MES_PIN_PLL] && !startReq)
    |=> (state_reg == MES_ST_WAIT) && (curMode_reg == $past(curMode_reg)))
    else $error("transition finished before PLL lock");
  AST_CFG_HOLD: assert property (@(posedge mclk) disable iff (rst)
    ((state_reg == MES_ST_IDLE) && ($past(state_reg) == MES_ST_IDLE)) |-> $stable(activeCfg_reg))
    else $error("configuration changed outside mode entry");
  AST_HW_RESET: assert property (@(posedge mclk) disable iff (rst)
    resetRise |=> (state_reg == MES_ST_FETCH) && (target_reg == MES_M_RESET))
    else $error("hardware failure did not start reset transition");
  AST_MODE_CODE: assert property (@(posedge mclk) disable iff (rst)
    !(curMode_reg inside {4'h9, 4'hb, 4'hc, 4'he, 4'hf}))
    else $error("reserved mode code reported");
  AST_DC: assert property (@(posedge mclk) disable iff (rst)
    $rose(gsRd[MES_GS_DC]) |-> $past(state_reg) == MES_ST_APPLY)
    else $error("consumption status changed outside mode entry");
  AST_KEY_DISCARD: assert property (@(posedge mclk) disable iff (rst)
    (mctlWr && !swReq && (state_reg == MES_ST_IDLE) && !resetRise && !safeRise && !wakeReq && !waitEntry)
    |=> (state_reg == MES_ST_IDLE))
    else $error("unkeyed write started a transition");
endmodule : mes_mode_entry_sequencer

// ---- core/mes_pkg.sv ----
// Constants, register map and types for the mode entry sequencer
// =============================================================
// Notes on behaviour
// - A per-mode enable mask is checked before a software or wait-entry request enters its mode.
// - Requesting a disabled mode raises the illegal-mode interrupt instead of entering.
// - Reset, safe, default run and run zero enable bits always read one.
// - Writable enable bits: zero means mode disabled, one means mode enabled.
// - Transition-in-progress reads one during a mode change, zero once complete.
// - Done flag set for run-class transitions, not low-power entries except via wait.
// - Target mode's configuration drives oscillator, PLL, flash and regulator enables.
// - Transition completes only when enabled oscillator is stable and enabled PLL locked.
// - Configuration writes take effect only at the next entry into that mode.
// - Hardware starts transitions: wake-up exit, safe on failure, reset on failure.
// - Current mode reported as the documented 4-bit code; reserved codes never appear.
// - Consumption status is one when the main regulator is required, else zero.
package mes_pkg;

  // =============================================================
  // Mode codes
  typedef logic [3:0] mes_mode_t;
  localparam mes_mode_t MES_M_RESET = 4'h0;
  localparam mes_mode_t MES_M_SAFE = 4'h2;
  localparam mes_mode_t MES_M_DEFAULT_RUN = 4'h3;
  localparam mes_mode_t MES_M_APP_RUN_THREE = 4'h7;
  localparam mes_mode_t MES_M_HALT = 4'h8;
  localparam mes_mode_t MES_M_STOP = 4'ha;
  localparam mes_mode_t MES_M_STANDBY = 4'hd;

  // =============================================================
  // Register byte addresses
  localparam logic [31:0] MES_ADDR_ME = 32'hc3fdc800;
  localparam logic [31:0] MES_ADDR_GS = 32'hc3fdc804;
  localparam logic [31:0] MES_ADDR_MCTL = 32'hc3fdc808;
  localparam logic [31:0] MES_ADDR_IRQ_STAT = 32'hc3fdc80c;
  localparam logic [31:0] MES_ADDR_IRQ_CLR = 32'hc3fdc810;
  localparam logic [31:0] MES_ADDR_IRQ_EN = 32'hc3fdc814;
  localparam logic [31:0] MES_ADDR_CFG0 = 32'hc3fdc840;
  localparam int MES_CFG_BLK_LSB = 6;

  // =============================================================
  // Field layouts and reset values
  localparam logic [31:0] MES_ME_FIXED = 32'h0000001d;
  localparam logic [31:0] MES_ME_WRITABLE = 32'h000025e2;
  localparam logic [31:0] MES_ME_RST = 32'h00000000;
  localparam logic [15:0] MES_KEY = 16'h5af0;
  localparam logic [15:0] MES_KEY_INV = 16'ha50f;
  localparam int MES_MCTL_MODE_LSB = 28;
  localparam int MES_GS_MODE_LSB = 28;
  localparam int MES_GS_MTRANS = 27;
  localparam int MES_GS_DC = 26;
  localparam int MES_IRQ_W = 2;
  localparam int MES_IRQ_DONE = 0;
  localparam int MES_IRQ_ILL = 1;
  localparam int MES_CFG_W = 4;
  localparam int MES_CFG_AW = 4;
  localparam int MES_CFG_OSC = 0;
  localparam int MES_CFG_PLL = 1;
  localparam int MES_CFG_FLASH = 2;
  localparam int MES_CFG_MVREG = 3;
  localparam logic [MES_CFG_W-1:0] MES_CFG_RST = 4'hf;

  // =============================================================
  // Pin synchroniser lanes
  localparam int MES_SYNC_W = 5;
  localparam int MES_PIN_OSC = 0;
  localparam int MES_PIN_PLL = 1;
  localparam int MES_PIN_WAKE = 2;
  localparam int MES_PIN_SAFE = 3;
  localparam int MES_PIN_RESET = 4;

  // =============================================================
  // Bus read sequencing and sequencer states
  localparam logic [1:0] MES_RD_IDLE = 2'h0;
  localparam logic [1:0] MES_RD_FIRST = 2'h1;
  localparam logic [1:0] MES_RD_LOAD = 2'h2;
  localparam logic [1:0] MES_RD_LAST = 2'h3;
  localparam int MES_HTRANS_ACT = 1;

  typedef enum logic [1:0] {
    MES_ST_IDLE = 2'b00,
    MES_ST_FETCH = 2'b01,
    MES_ST_APPLY = 2'b10,
    MES_ST_WAIT = 2'b11
  } mes_state_e;

endpackage : mes_pkg

// ---- core/mes_sync.sv ----
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module mes_sync #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  initial begin
    if (W < 1) $error("mes_sync: W must be at least 1");
  end

  // =============================================================
  // One lane per input; the first stage feeds only the second
  for (genvar i = 0; i < W; i++) begin : gLane
    logic s1_reg, s2_reg, s3_reg, out_reg;
    always_ff @(posedge mclk) begin
      if (rst) begin
        s1_reg <= 1'b0;
        s2_reg <= 1'b0;
        s3_reg <= 1'b0;
        out_reg <= 1'b0;
      end else begin
        s1_reg <= din[i];
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
        if (s2_reg == s3_reg) begin
          out_reg <= s3_reg;
        end
      end
    end
    assign dout[i] = out_reg;
  end
endmodule : mes_sync
